//--- rtl/fqb_regs.vh
// query table indices, fixed values, field positions and own register map
`ifndef FQB_REGS_VH
`define FQB_REGS_VH

// ----------------------------------------------------------------------
// query indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define FQB_IDX_WORD_WIDTH       10'h028
`define FQB_IDX_PAGE_READ_EXP    10'h127
`define FQB_IDX_BURST_COUNT      10'h128
`define FQB_IDX_BURST_OPT1       10'h129
`define FQB_IDX_BURST_OPT2       10'h12A
`define FQB_IDX_BURST_OPT3       10'h12B
`define FQB_IDX_BURST_OPT4       10'h12C
`define FQB_IDX_REGION_COUNT     10'h12D
`define FQB_IDX_IDENT_PART       10'h12E
`define FQB_IDX_OPS_WITHIN       10'h130
`define FQB_IDX_OPS_PROGRAM      10'h131
`define FQB_IDX_OPS_ERASE        10'h132
`define FQB_IDX_ERASE_TYPES      10'h133
`define FQB_IDX_TYPE1_GEOM       10'h134
`define FQB_IDX_TYPE1_ENDUR      10'h138
`define FQB_IDX_TYPE1_CELL       10'h13A
`define FQB_IDX_TYPE1_CAPS       10'h13B
`define FQB_IDX_TYPE2_GEOM       10'h13C
`define FQB_IDX_TYPE2_ENDUR      10'h140
`define FQB_IDX_TYPE2_CELL       10'h142
`define FQB_IDX_TYPE2_CAPS       10'h143

// ----------------------------------------------------------------------
// own control and status registers
// ----------------------------------------------------------------------
`define FQB_IDX_READ_CFG         10'h180
`define FQB_IDX_BURST_STATUS     10'h181

// ----------------------------------------------------------------------
// fixed query values
// ----------------------------------------------------------------------
`define FQB_VAL_PAGE_READ_EXP    8'h03
`define FQB_VAL_BURST_COUNT      8'h04
`define FQB_VAL_BURST_OPT1       8'h01
`define FQB_VAL_BURST_OPT2       8'h02
`define FQB_VAL_BURST_OPT3       8'h03
`define FQB_VAL_BURST_OPT4       8'h07

// ----------------------------------------------------------------------
// field layouts and masks
// ----------------------------------------------------------------------
`define FQB_BURST_CODE_MSB       2
`define FQB_BURST_CODE_CONT      3'h7
`define FQB_BURST_OPT_MASK       8'h07
`define FQB_CELL_MASK            8'h1F
`define FQB_CAPS_MASK            8'h07
`define FQB_READ_CFG_RESET       3'h7
`define FQB_STAT_SUPPORTED_BIT   0
`define FQB_STAT_CONT_BIT        1
`define FQB_STAT_WORDS_LSB       8
`define FQB_STAT_BYTES_LSB       16

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define FQB_RESP_OKAY            2'h0
`define FQB_RESP_SLVERR          2'h2
`define FQB_RESP_DECERR          2'h3

`endif

//--- rtl/fqb_query_table.v
// read-only query table for burst, partition and erase-block data, AXI4-Lite slave
//
// Overview of operation
// - page-read byte holds exponent 03, eight bytes
// - word width byte scales page and burst sizes
// - burst field count at 128 reads 04
// - burst fields: code in bits 0-2, rest zero
// - code 07 means continuous linear burst
// - burst code usable directly as read config
// - burst options 129-12C read 01,02,03,07
// - region count at 12D; zero hides fields
// - identical partition count, two bytes at 12E
// - ops byte: program bits 0-3, erase 4-7
// - byte 131 ops allowed while programming
// - byte 132 ops allowed while erasing
// - erase type count zero means bulk erase
// - descriptor: y+1 blocks, z times 256 bytes
// - endurance field in units of 1000 cycles
// - cell byte: bits per cell, ECC flag bit 4
// - access caps: page, sync read, sync write
// - second descriptor set only when bottom parameter
// - reserved bits read as zero
`timescale 1ns/100ps
`include "fqb_regs.vh"

module fqb_query_table #(
	parameter [7:0]  WORD_WIDTH_CODE = 8'h01,
	parameter        BOTTOM_PARAM    = 1,
	parameter [7:0]  REGION_COUNT    = 8'h02,
	parameter [15:0] IDENT_PARTS     = 16'h0001,
	parameter [7:0]  OPS_WITHIN      = 8'h11,
	parameter [7:0]  OPS_PROGRAM     = 8'h10,
	parameter [7:0]  OPS_ERASE       = 8'h01,
	parameter [7:0]  ERASE_TYPES     = 8'h02,
	parameter [31:0] TYPE1_GEOM      = 32'h0080_0003,
	parameter [15:0] TYPE1_ENDUR     = 16'h0064,
	parameter [7:0]  TYPE1_CELL      = 8'h02,
	parameter [7:0]  TYPE1_CAPS      = 8'h03,
	parameter [31:0] TYPE2_GEOM      = 32'h0200_0000,
	parameter [15:0] TYPE2_ENDUR     = 16'h0064,
	parameter [7:0]  TYPE2_CELL      = 8'h02,
	parameter [7:0]  TYPE2_CAPS      = 8'h03
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	reg [9:0]  aw_idx_reg;
	reg        aw_full_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        w_full_reg;
	reg [2:0]  read_cfg_reg;

	// ----------------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------------
	// true where a query byte lives; writes there are refused
	function is_table;
		input [9:0] idx;
		begin
			is_table = (idx == `FQB_IDX_WORD_WIDTH) ||
				((idx >= `FQB_IDX_PAGE_READ_EXP) && (idx <= `FQB_IDX_TYPE2_CAPS));
		end
	endfunction

	function is_mapped;
		input [9:0] idx;
		begin
			is_mapped = is_table(idx) || (idx == `FQB_IDX_READ_CFG) ||
				(idx == `FQB_IDX_BURST_STATUS);
		end
	endfunction

	// burst words at full width; zero for continuous or unsupported
	function [7:0] burst_words;
		input [2:0] code;
		begin
			case (code)
			3'h1:    burst_words = 8'h04;
			3'h2:    burst_words = 8'h08;
			3'h3:    burst_words = 8'h10;
			default: burst_words = 8'h00;
			endcase
		end
	endfunction

	function code_supported;
		input [2:0] code;
		begin
			code_supported = (code == `FQB_VAL_BURST_OPT1) || (code == `FQB_VAL_BURST_OPT2) ||
				(code == `FQB_VAL_BURST_OPT3) || (code == `FQB_VAL_BURST_OPT4);
		end
	endfunction

	// ----------------------------------------------------------------------
	// query byte lookup
	// ----------------------------------------------------------------------
	function [7:0] query_byte;
		input [9:0] idx;
		reg         regions_on;
		reg         blocks_on;
		reg         type2_on;
		reg [7:0]   b;
		begin
			regions_on = (REGION_COUNT != 8'h00);
			blocks_on  = regions_on && (ERASE_TYPES != 8'h00);
			type2_on   = blocks_on && (BOTTOM_PARAM != 0) && (ERASE_TYPES >= 8'h02);
			b = 8'h00;
			case (idx)
			`FQB_IDX_WORD_WIDTH:    b = WORD_WIDTH_CODE;
			`FQB_IDX_PAGE_READ_EXP: b = `FQB_VAL_PAGE_READ_EXP;
			`FQB_IDX_BURST_COUNT:   b = `FQB_VAL_BURST_COUNT;
			`FQB_IDX_BURST_OPT1:    b = `FQB_VAL_BURST_OPT1 & `FQB_BURST_OPT_MASK;
			`FQB_IDX_BURST_OPT2:    b = `FQB_VAL_BURST_OPT2 & `FQB_BURST_OPT_MASK;
			`FQB_IDX_BURST_OPT3:    b = `FQB_VAL_BURST_OPT3 & `FQB_BURST_OPT_MASK;
			`FQB_IDX_BURST_OPT4:    b = `FQB_VAL_BURST_OPT4 & `FQB_BURST_OPT_MASK;
			`FQB_IDX_REGION_COUNT:  b = REGION_COUNT;
			`FQB_IDX_IDENT_PART:    b = regions_on ? IDENT_PARTS[7:0] : 8'h00;
			10'h12F:                b = regions_on ? IDENT_PARTS[15:8] : 8'h00;
			`FQB_IDX_OPS_WITHIN:    b = regions_on ? OPS_WITHIN : 8'h00;
			`FQB_IDX_OPS_PROGRAM:   b = regions_on ? OPS_PROGRAM : 8'h00;
			`FQB_IDX_OPS_ERASE:     b = regions_on ? OPS_ERASE : 8'h00;
			`FQB_IDX_ERASE_TYPES:   b = regions_on ? ERASE_TYPES : 8'h00;
			`FQB_IDX_TYPE1_GEOM:    b = blocks_on ? TYPE1_GEOM[7:0] : 8'h00;
			10'h135:                b = blocks_on ? TYPE1_GEOM[15:8] : 8'h00;
			10'h136:                b = blocks_on ? TYPE1_GEOM[23:16] : 8'h00;
			10'h137:                b = blocks_on ? TYPE1_GEOM[31:24] : 8'h00;
			`FQB_IDX_TYPE1_ENDUR:   b = blocks_on ? TYPE1_ENDUR[7:0] : 8'h00;
			10'h139:                b = blocks_on ? TYPE1_ENDUR[15:8] : 8'h00;
			`FQB_IDX_TYPE1_CELL:    b = blocks_on ? (TYPE1_CELL & `FQB_CELL_MASK) : 8'h00;
			`FQB_IDX_TYPE1_CAPS:    b = blocks_on ? (TYPE1_CAPS & `FQB_CAPS_MASK) : 8'h00;
			`FQB_IDX_TYPE2_GEOM:    b = type2_on ? TYPE2_GEOM[7:0] : 8'h00;
			10'h13D:                b = type2_on ? TYPE2_GEOM[15:8] : 8'h00;
			10'h13E:                b = type2_on ? TYPE2_GEOM[23:16] : 8'h00;
			10'h13F:                b = type2_on ? TYPE2_GEOM[31:24] : 8'h00;
			`FQB_IDX_TYPE2_ENDUR:   b = type2_on ? TYPE2_ENDUR[7:0] : 8'h00;
			10'h141:                b = type2_on ? TYPE2_ENDUR[15:8] : 8'h00;
			`FQB_IDX_TYPE2_CELL:    b = type2_on ? (TYPE2_CELL & `FQB_CELL_MASK) : 8'h00;
			`FQB_IDX_TYPE2_CAPS:    b = type2_on ? (TYPE2_CAPS & `FQB_CAPS_MASK) : 8'h00;
			default:                b = 8'h00;
			endcase
			query_byte = b;
		end
	endfunction

	// ----------------------------------------------------------------------
	// burst status derived from the read configuration
	// ----------------------------------------------------------------------
	wire [7:0]  cfg_words  = burst_words(read_cfg_reg);
	wire [15:0] cfg_bytes  = {8'h00, cfg_words} << WORD_WIDTH_CODE[3:0];
	wire        cfg_cont   = (read_cfg_reg == `FQB_BURST_CODE_CONT);
	wire        cfg_ok     = code_supported(read_cfg_reg);

	reg [31:0] status_word;
	always @* begin
		status_word = 32'h0000_0000;
		status_word[`FQB_STAT_SUPPORTED_BIT] = cfg_ok;
		status_word[`FQB_STAT_CONT_BIT] = cfg_cont;
		status_word[`FQB_STAT_WORDS_LSB +: 8] = cfg_words;
		status_word[`FQB_STAT_BYTES_LSB +: 16] = cfg_bytes;
	end

	// ----------------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------------
	wire [9:0] ar_idx = s_axi_araddr[11:2];
	reg  [31:0] rd_word;
	always @* begin
		rd_word = 32'h0000_0000;
		if (is_table(ar_idx)) begin
			rd_word = {24'h00_0000, query_byte(ar_idx)};
		end else if (ar_idx == `FQB_IDX_READ_CFG) begin
			rd_word = {29'h0000_0000, read_cfg_reg};
		end else if (ar_idx == `FQB_IDX_BURST_STATUS) begin
			rd_word = status_word;
		end
	end

	// ----------------------------------------------------------------------
	// write channel: address and data in either order, then response
	// ----------------------------------------------------------------------
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_idx_reg    <= 10'h000;
			aw_full_reg   <= 1'b0;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			w_full_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FQB_RESP_OKAY;
			read_cfg_reg  <= `FQB_READ_CFG_RESET;
		end else begin
			if (aw_take) begin
				aw_idx_reg    <= s_axi_awaddr[11:2];
				aw_full_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_full_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_idx_reg == `FQB_IDX_READ_CFG) begin
					if (w_strb_reg[0])
						read_cfg_reg <= w_data_reg[`FQB_BURST_CODE_MSB:0];
					s_axi_bresp <= `FQB_RESP_OKAY;
				end else if (is_mapped(aw_idx_reg)) begin
					s_axi_bresp <= `FQB_RESP_SLVERR;
				end else begin
					s_axi_bresp <= `FQB_RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// read channel: one-cycle answer, one read in flight
	// ----------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `FQB_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= is_mapped(ar_idx) ? `FQB_RESP_OKAY : `FQB_RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

//--- tb/fqb_checker.sv
// concurrent checks on the query table bus ports
`timescale 1ns/100ps
module fqb_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	reg  [9:0] ri_reg;
	reg  [9:0] wi_reg;
	wire [7:0] rb = s_axi_rdata[7:0];
	// index of the request now being answered
	always @(posedge aclk) begin
		if (!aresetn) begin
			ri_reg <= 10'h000;
			wi_reg <= 10'h000;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				ri_reg <= s_axi_araddr[11:2];
			if (s_axi_awvalid && s_axi_awready)
				wi_reg <= s_axi_awaddr[11:2];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_out;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	AST_RD_ANSWER: assert property (s_ar_take |=> s_r_out)
		else $error("read answer missing");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_PAGE_EXP: assert property (s_axi_rvalid && ri_reg == 10'h127 |-> s_axi_rdata == 32'h00000003)
		else $error("page read exponent wrong");
	AST_FIELD_CNT: assert property (s_axi_rvalid && ri_reg == 10'h128 |-> s_axi_rdata == 32'h00000004)
		else $error("burst field count wrong");
	AST_OPT_VALS: assert property (s_axi_rvalid && ri_reg inside {[10'h129:10'h12B]} |-> rb == ri_reg[7:0] - 8'h28)
		else $error("burst option wrong");
	AST_CONT_CODE: assert property (s_axi_rvalid && ri_reg == 10'h12C |-> rb == 8'h07)
		else $error("continuous code wrong");
	AST_OPT_RSVD: assert property (s_axi_rvalid && ri_reg inside {[10'h129:10'h12C]} |-> rb[7:3] == 5'h00)
		else $error("burst option reserved bits set");
	AST_UPPER_ZERO: assert property (s_axi_rvalid && ri_reg < 10'h180 |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper query bits set");
	AST_CELL_MASK: assert property (s_axi_rvalid && (ri_reg == 10'h13A || ri_reg == 10'h142) |-> rb[7:5] == 3'h0)
		else $error("cell byte reserved bits set");
	AST_CAPS_MASK: assert property (s_axi_rvalid && (ri_reg == 10'h13B || ri_reg == 10'h143) |-> rb[7:3] == 5'h00)
		else $error("caps byte reserved bits set");
	AST_WR_REFUSE: assert property ($rose(s_axi_bvalid) && wi_reg inside {[10'h127:10'h143]} |-> s_axi_bresp == 2'h2)
		else $error("query write not refused");
endmodule

//--- tb/fqb_axi_master.sv
// bus master model standing in for the host reading query space
`timescale 1ns/100ps
module fqb_axi_master (
	input  wire        aclk,
	output reg  [11:0] awaddr,
	output reg         awvalid,
	input  wire        awready,
	output reg  [31:0] wdata,
	output reg  [3:0]  wstrb,
	output reg         wvalid,
	input  wire        wready,
	input  wire [1:0]  bresp,
	input  wire        bvalid,
	output reg         bready,
	output reg  [11:0] araddr,
	output reg         arvalid,
	input  wire        arready,
	input  wire [31:0] rdata,
	input  wire [1:0]  rresp,
	input  wire        rvalid,
	output reg         rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = 47'h0;
		{araddr, arvalid, rready} = 14'h0;
		wstrb = 4'hF;
	end
	task wr(input [11:0] a, input [31:0] d, output [1:0] r);
		reg done;
		done = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			// released payload shows inverted value
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task rd(input [11:0] a, output [31:0] d, output [1:0] r);
		reg done;
		done = 1'b0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
endmodule

//--- tb/fqb_query_table_bench.sv
// self-checking bench for the query table
`timescale 1ns/100ps
`include "fqb_regs.vh"
module fqb_query_table_bench;
	localparam [7:0]  WW = 8'h02;
	localparam [15:0] IP = 16'h0203;
	localparam [31:0] G1 = 32'h0080_0003;
	localparam [31:0] G2 = 32'h0200_0000;
	localparam [15:0] E1 = 16'h0064;
	localparam [7:0]  C1 = 8'hF2;
	localparam [7:0]  K1 = 8'hFB;
	reg         aclk;
	reg         aresetn;
	wire [11:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0]  wstrb;
	wire [1:0]  bresp, rresp;
	wire        awvalid, awready, wvalid, wready, bvalid, bready;
	wire        arvalid, arready, rvalid, rready;
	integer     fails, compares, i;
	integer     cyc = 0;
	reg  [17:0] tbl [0:23];
	reg  [31:0] d;
	reg  [1:0]  r;
	reg  [2:0]  c;
	reg  [7:0]  w;
	reg         sup;

	fqb_axi_master m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	fqb_query_table #(.WORD_WIDTH_CODE(WW), .IDENT_PARTS(IP), .OPS_WITHIN(8'h21), .TYPE1_GEOM(G1),
		.TYPE1_ENDUR(E1), .TYPE1_CELL(C1), .TYPE1_CAPS(K1), .TYPE2_GEOM(G2)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	task chk(input [31:0] g, input [31:0] x);
		compares = compares + 1;
		if (g !== x) begin
			fails = fails + 1;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask
	task rd_chk(input [17:0] t);
		m.rd({t[17:8], 2'b00}, d, r);
		chk(d, {24'h000000, t[7:0]});
		chk({30'h0, r}, {30'h0, `FQB_RESP_OKAY});
	endtask
	task print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			print_verdict;
		end
	end
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		fails = 0;
		compares = 0;
		tbl = '{{10'h127, 8'h03}, {10'h128, 8'h04}, {10'h129, 8'h01}, {10'h12A, 8'h02}, {10'h12B, 8'h03},
			{10'h12C, 8'h07}, {10'h028, WW}, {10'h12D, 8'h02}, {10'h12E, IP[7:0]}, {10'h12F, IP[15:8]},
			{10'h130, 8'h21}, {10'h131, 8'h10}, {10'h132, 8'h01}, {10'h133, 8'h02}, {10'h134, G1[7:0]},
			{10'h135, G1[15:8]}, {10'h136, G1[23:16]}, {10'h137, G1[31:24]}, {10'h138, E1[7:0]},
			{10'h139, E1[15:8]}, {10'h13A, C1 & 8'h1F}, {10'h13B, K1 & 8'h07}, {10'h13C, G2[7:0]},
			{10'h13F, G2[31:24]}};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 6; i++) rd_chk(tbl[i]);
		for (i = 6; i < 14; i++) rd_chk(tbl[i]);
		for (i = 14; i < 24; i++) rd_chk(tbl[i]);
		for (i = 0; i < 6; i++) begin
			m.wr({tbl[i][17:8], 2'b00}, 32'h00000000, r);
			chk({30'h0, r}, {30'h0, `FQB_RESP_SLVERR});
			rd_chk(tbl[i]);
		end
		m.wr(12'hFFC, 32'h00000005, r);
		chk({30'h0, r}, {30'h0, `FQB_RESP_DECERR});
		m.rd(12'hFFC, d, r);
		chk({d[29:0], r}, {30'h0, `FQB_RESP_DECERR});
		m.rd(12'h600, d, r);
		chk(d, 32'h00000007);
		for (i = 0; i < 8; i++) begin
			c = i[2:0];
			sup = (c == 3'h7) || (c != 3'h0 && c < 3'h4);
			w = (sup && c != 3'h7) ? (8'h01 << (c + 3'h1)) : 8'h00;
			m.wr(12'h600, {29'h0, c}, r);
			chk({30'h0, r}, {30'h0, `FQB_RESP_OKAY});
			m.rd(12'h600, d, r);
			chk(d, {29'h0, c});
			m.rd(12'h604, d, r);
			chk(d, {{8'h00, w} << WW[3:0], w, 6'h00, c == 3'h7, sup});
		end
		// a write with the low strobe off leaves the setting alone
		@(posedge aclk);
		m.wstrb <= 4'h0;
		m.wr(12'h600, 32'h00000001, r);
		chk({30'h0, r}, {30'h0, `FQB_RESP_OKAY});
		m.rd(12'h600, d, r);
		chk(d, 32'h00000007);
		@(posedge aclk);
		m.wstrb <= 4'hF;
		print_verdict;
	end
endmodule

bind fqb_query_table fqb_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);
